// File: shared/dcf_map.vh
`ifndef DCF_MAP_VH
`define DCF_MAP_VH
// register byte offsets
`define DCF_REG_CTRL 8'h00
`define DCF_REG_STATUS 8'h04
`define DCF_REG_OFFSET 8'h08
// control fields
`define DCF_CTRL_CLEAR 0
`define DCF_CTRL_INHIBIT 1
// status fields
`define DCF_ST_COUNT_LSB 0
`define DCF_ST_FLAG_LSB 16
`define DCF_ST_MODE 24
`define DCF_ST_SERIAL 25
// offset readback fields
`define DCF_OFS_EMPTY_LSB 0
`define DCF_OFS_FULL_LSB 16
// default offsets
`define DCF_OFS_DEF_PAR 13'h007F
`define DCF_OFS_DEF_SER 13'h03FF
// read-clock transitions before a fall-through word shows
`define DCF_FT_LAST 2'h2
// synchroniser reset pattern, active-low pins idle high
`define DCF_SYNC_RST 29'h17F0_0000
// responses
`define DCF_RESP_OKAY 2'h0
`define DCF_RESP_SLVERR 2'h2
`define DCF_ZERO32 32'h0000_0000
`endif

// File: src/dcf_fifo.v
// Operation
// - write clock edge with enable stores input word
// - read clock edge with enable outputs next word
// - output bus tristated by output enable pin; the code drives the bus always and only forwards the pin on DATA_OUT_EN_N_O
// - write and read clocks fully independent
// - standard mode: first word needs explicit read
// - fall-through: first word after three transitions
// - mode latched from shared pin during reset
// - fall-through mode allows direct cascading
// - shared flags: empty/full or output/input ready
// - half, almost-empty, almost-full in both modes
// - default thresholds 127 or 1023 words
// - serial enable plus load shifts offset bit
// - write enable plus load loads offsets parallel
// - read enable plus load reads offsets back
// - master reset zeroes both pointers
// - load pin picks default and programming method
// - flags updated after master reset
// - partial reset keeps mode, method and offsets
// - retransmit low resets read pointer
// - standby whenever no operation in progress
// - storage 18 bits wide, 8192 or 16384 deep
// - almost-full low above capacity minus offset
// - almost-empty low below empty offset
// - both resets zero the output register
// - retransmit blanks empty flag, keeps settings
//
// The AXI4-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "dcf_map.vh"
module dcf_fifo #(
  parameter WIDTH = 18,
  parameter DEPTH = 8192,
  parameter ADDR_W = 13
) (
  // system
  input wire CLK_I,
  input wire RST_I,
  // write side pins
  input wire WRITE_CLK_I,
  input wire WRITE_EN_N_I,
  input wire [WIDTH-1:0] DATA_IN_BUS_I,
  // read side pins
  input wire READ_CLK_I,
  input wire READ_EN_N_I,
  input wire OUT_EN_N_I,
  input wire RETRANSMIT_STROBE_N_I,
  // control pins
  input wire FULL_RESET_INPUT_N_I,
  input wire SOFT_CLEAR_INPUT_N_I,
  input wire OFFSET_LOAD_SELECT_N_I,
  input wire SERIAL_LOAD_ENABLE_N_I,
  input wire MODE_SELECT_SERIAL_IN_I,
  // data out and flags
  output reg [WIDTH-1:0] DATA_OUT_BUS_O,
  output reg DATA_OUT_EN_N_O,
  output reg EMPTY_FLAG_O,
  output reg FULL_FLAG_O,
  output reg HALF_FULL_LEVEL_N_O,
  output reg ALMOST_EMPTY_FLAG_N_O,
  output reg ALMOST_FULL_FLAG_N_O,
  output reg STANDBY_O,
  // axi4-lite write
  input wire [7:0] S_AXI_AWADDR_I,
  input wire S_AXI_AWVALID_I,
  output reg S_AXI_AWREADY_O,
  input wire [31:0] S_AXI_WDATA_I,
  input wire [3:0] S_AXI_WSTRB_I,
  input wire S_AXI_WVALID_I,
  output reg S_AXI_WREADY_O,
  output reg [1:0] S_AXI_BRESP_O,
  output reg S_AXI_BVALID_O,
  input wire S_AXI_BREADY_I,
  // axi4-lite read
  input wire [7:0] S_AXI_ARADDR_I,
  input wire S_AXI_ARVALID_I,
  output reg S_AXI_ARREADY_O,
  output reg [31:0] S_AXI_RDATA_O,
  output reg [1:0] S_AXI_RRESP_O,
  output reg S_AXI_RVALID_O,
  input wire S_AXI_RREADY_I
);

  localparam [ADDR_W:0] FULL_CNT = {1'b1, {ADDR_W{1'b0}}};
  localparam [ADDR_W:0] HALF_CNT = {2'b01, {(ADDR_W-1){1'b0}}};
  // offset registers keep 13 bits whatever the depth
  localparam OFS_W = 13;
  localparam CMP_W = ADDR_W + OFS_W + 2;

  // pin synchronisers, two flops then edge history
  wire [28:0] pins_in;
  reg [28:0] sync1_r;
  reg [28:0] sync2_r;
  reg [1:0] clk_hist_r;
  assign pins_in = {OUT_EN_N_I, MODE_SELECT_SERIAL_IN_I, RETRANSMIT_STROBE_N_I,
                    SOFT_CLEAR_INPUT_N_I, FULL_RESET_INPUT_N_I, SERIAL_LOAD_ENABLE_N_I,
                    OFFSET_LOAD_SELECT_N_I, READ_EN_N_I, WRITE_EN_N_I, READ_CLK_I,
                    WRITE_CLK_I, DATA_IN_BUS_I};
  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      sync1_r <= `DCF_SYNC_RST;
      sync2_r <= `DCF_SYNC_RST;
      clk_hist_r <= 2'h0;
    end else begin
      sync1_r <= pins_in;
      sync2_r <= sync1_r;
      clk_hist_r <= sync2_r[19:18];
    end
  end

  wire [WIDTH-1:0] din = sync2_r[WIDTH-1:0];
  wire wr_rise = sync2_r[18] & ~clk_hist_r[0];
  wire rd_rise = sync2_r[19] & ~clk_hist_r[1];
  wire rd_tog = sync2_r[19] ^ clk_hist_r[1];
  wire wen = ~sync2_r[20];
  wire ren = ~sync2_r[21];
  wire ld = ~sync2_r[22];
  wire serial_load_enable = ~sync2_r[23];
  wire full_reset_input = ~sync2_r[24];
  wire prs_pin = ~sync2_r[25];
  wire rt = ~sync2_r[26];
  wire si = sync2_r[27];
  wire oe_n = sync2_r[28];

  // storage and state
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [ADDR_W-1:0] wptr_r;
  reg [ADDR_W-1:0] rptr_r;
  reg [ADDR_W:0] count_r;
  reg [ADDR_W:0] count_nxt;
  reg [WIDTH-1:0] q_r;
  reg ov_r;
  reg rt_block_r;
  reg [1:0] ft_cnt_r;
  reg fall_through_mode_r;
  reg serial_r;
  reg [OFS_W-1:0] empty_off_r;
  reg [OFS_W-1:0] full_off_r;
  reg ld_sel_r;
  reg rb_sel_r;
  reg clr_pulse_r;
  reg inhibit_r;

  wire soft_clear_input = prs_pin | clr_pulse_r;
  wire empty = (count_r == {(ADDR_W+1){1'b0}});
  wire full = (count_r == FULL_CNT);
  wire rt_act = rd_rise & rt;
  // full fifo refuses data words
  wire do_write = wr_rise & wen & ~ld & ~full & ~inhibit_r;
  wire rd_ok = ~ld & ~rt_act & ~rt_block_r & ~empty;
  wire do_read_std = ~fall_through_mode_r & rd_rise & ren & rd_ok;
  wire ft_pend = fall_through_mode_r & ~ov_r & ~empty & ~rt_block_r;
  wire ft_load = ft_pend & rd_tog & (ft_cnt_r == `DCF_FT_LAST);
  wire adv = fall_through_mode_r & ov_r & rd_rise & ren & ~ld & ~rt_act;
  wire adv_load = adv & ~empty;
  wire pop = do_read_std | ft_load | adv_load;
  wire ofs_read = rd_rise & ren & ld;
  wire par_load = wr_rise & wen & ld & ~serial_r;
  wire ser_shift = wr_rise & serial_load_enable & ld & serial_r;
  wire [CMP_W-1:0] cnt_ext = {{(OFS_W+1){1'b0}}, count_r};
  wire [CMP_W-1:0] eofs_ext = {{(ADDR_W+2){1'b0}}, empty_off_r};
  wire [CMP_W-1:0] fofs_ext = {{(ADDR_W+2){1'b0}}, full_off_r};
  wire [CMP_W-1:0] cap_ext = {{(OFS_W+1){1'b0}}, FULL_CNT};
  wire [CMP_W-1:0] paf_sum = cnt_ext + fofs_ext;

  always @* begin
    count_nxt = count_r;
    if (rt_act) begin
      count_nxt = {1'b0, wptr_r} + {{ADDR_W{1'b0}}, do_write};
    end else if (do_write & ~pop) begin
      count_nxt = count_r + {{ADDR_W{1'b0}}, 1'b1};
    end else if (pop & ~do_write) begin
      count_nxt = count_r - {{ADDR_W{1'b0}}, 1'b1};
    end
  end

  always @(posedge CLK_I) begin
    if (do_write) begin
      mem[wptr_r] <= din;
    end
  end

  // data path, pointers, fall-through stage
  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      wptr_r <= {ADDR_W{1'b0}};
      rptr_r <= {ADDR_W{1'b0}};
      count_r <= {(ADDR_W+1){1'b0}};
      q_r <= {WIDTH{1'b0}};
      ov_r <= 1'b0;
      rt_block_r <= 1'b0;
      ft_cnt_r <= 2'h0;
    end else if (full_reset_input | soft_clear_input) begin
      wptr_r <= {ADDR_W{1'b0}};
      rptr_r <= {ADDR_W{1'b0}};
      count_r <= {(ADDR_W+1){1'b0}};
      q_r <= {WIDTH{1'b0}};
      ov_r <= 1'b0;
      rt_block_r <= 1'b0;
      ft_cnt_r <= 2'h0;
    end else begin
      count_r <= count_nxt;
      if (do_write) begin
        wptr_r <= wptr_r + {{(ADDR_W-1){1'b0}}, 1'b1};
      end
      if (rt_act) begin
        rptr_r <= {ADDR_W{1'b0}};
        rt_block_r <= 1'b1;
        ov_r <= 1'b0;
      end else begin
        if (rd_rise) begin
          rt_block_r <= 1'b0;
        end
        if (pop) begin
          q_r <= mem[rptr_r];
          rptr_r <= rptr_r + {{(ADDR_W-1){1'b0}}, 1'b1};
        end else if (ofs_read) begin
          q_r <= {{(WIDTH-OFS_W){1'b0}}, rb_sel_r ? full_off_r : empty_off_r};
        end
        if (ft_load | adv_load) begin
          ov_r <= 1'b1;
        end else if (adv) begin
          ov_r <= 1'b0;
        end
      end
      if (~ft_pend | ft_load) begin
        ft_cnt_r <= 2'h0;
      end else if (rd_tog) begin
        ft_cnt_r <= ft_cnt_r + 2'h1;
      end
    end
  end

  // mode, method and offsets
  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      fall_through_mode_r <= 1'b0;
      serial_r <= 1'b0;
      empty_off_r <= `DCF_OFS_DEF_PAR;
      full_off_r <= `DCF_OFS_DEF_PAR;
      ld_sel_r <= 1'b0;
      rb_sel_r <= 1'b0;
    end else if (full_reset_input) begin
      fall_through_mode_r <= si;
      serial_r <= ~ld;
      empty_off_r <= ld ? `DCF_OFS_DEF_PAR : `DCF_OFS_DEF_SER;
      full_off_r <= ld ? `DCF_OFS_DEF_PAR : `DCF_OFS_DEF_SER;
      ld_sel_r <= 1'b0;
      rb_sel_r <= 1'b0;
    end else if (soft_clear_input) begin
      ld_sel_r <= 1'b0;
      rb_sel_r <= 1'b0;
    end else begin
      if (par_load) begin
        ld_sel_r <= ~ld_sel_r;
        if (ld_sel_r) begin
          full_off_r <= din[OFS_W-1:0];
        end else begin
          empty_off_r <= din[OFS_W-1:0];
        end
      end else if (ser_shift) begin
        {full_off_r, empty_off_r} <= {full_off_r[OFS_W-2:0], empty_off_r, si};
      end
      if (ofs_read) begin
        rb_sel_r <= ~rb_sel_r;
      end
    end
  end

  // registered flags and pin outputs
  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      DATA_OUT_BUS_O <= {WIDTH{1'b0}};
      DATA_OUT_EN_N_O <= 1'b1;
      EMPTY_FLAG_O <= 1'b0;
      FULL_FLAG_O <= 1'b1;
      HALF_FULL_LEVEL_N_O <= 1'b1;
      ALMOST_EMPTY_FLAG_N_O <= 1'b0;
      ALMOST_FULL_FLAG_N_O <= 1'b1;
      STANDBY_O <= 1'b1;
    end else begin
      DATA_OUT_BUS_O <= q_r;
      DATA_OUT_EN_N_O <= oe_n;
      if (fall_through_mode_r) begin
        EMPTY_FLAG_O <= ~ov_r;
        FULL_FLAG_O <= full;
      end else begin
        EMPTY_FLAG_O <= ~empty & ~rt_block_r;
        FULL_FLAG_O <= ~full;
      end
      HALF_FULL_LEVEL_N_O <= ~(count_r > HALF_CNT);
      ALMOST_EMPTY_FLAG_N_O <= ~(cnt_ext < eofs_ext);
      ALMOST_FULL_FLAG_N_O <= ~(paf_sum > cap_ext);
      STANDBY_O <= ~(full_reset_input | soft_clear_input | ft_pend | (wr_rise & (wen | serial_load_enable)) |
                     (rd_rise & (ren | rt)));
    end
  end

  // axi4-lite slave
  reg aw_got_r;
  reg w_got_r;
  reg [7:0] awaddr_r;
  reg [31:0] wdata_r;
  reg wstrb0_r;
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = `DCF_ZERO32;
    case (S_AXI_ARADDR_I)
      `DCF_REG_CTRL: begin
        rd_mux[`DCF_CTRL_INHIBIT] = inhibit_r;
      end
      `DCF_REG_STATUS: begin
        rd_mux[`DCF_ST_COUNT_LSB +: ADDR_W+1] = count_r;
        rd_mux[`DCF_ST_FLAG_LSB +: 5] = {ALMOST_FULL_FLAG_N_O, ALMOST_EMPTY_FLAG_N_O,
                                         HALF_FULL_LEVEL_N_O, FULL_FLAG_O, EMPTY_FLAG_O};
        rd_mux[`DCF_ST_MODE] = fall_through_mode_r;
        rd_mux[`DCF_ST_SERIAL] = serial_r;
      end
      `DCF_REG_OFFSET: begin
        rd_mux[`DCF_OFS_EMPTY_LSB +: OFS_W] = empty_off_r;
        rd_mux[`DCF_OFS_FULL_LSB +: OFS_W] = full_off_r;
      end
      default: begin
        rd_mux = `DCF_ZERO32;
      end
    endcase
  end
  wire ar_known = (S_AXI_ARADDR_I == `DCF_REG_CTRL) | (S_AXI_ARADDR_I == `DCF_REG_STATUS) |
                  (S_AXI_ARADDR_I == `DCF_REG_OFFSET);
  wire aw_known = (awaddr_r == `DCF_REG_CTRL) | (awaddr_r == `DCF_REG_STATUS) |
                  (awaddr_r == `DCF_REG_OFFSET);
  wire do_reg_wr = aw_got_r & w_got_r & ~S_AXI_BVALID_O;

  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= `DCF_ZERO32;
      wstrb0_r <= 1'b0;
      S_AXI_AWREADY_O <= 1'b0;
      S_AXI_WREADY_O <= 1'b0;
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O <= `DCF_RESP_OKAY;
      S_AXI_ARREADY_O <= 1'b0;
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RDATA_O <= `DCF_ZERO32;
      S_AXI_RRESP_O <= `DCF_RESP_OKAY;
      clr_pulse_r <= 1'b0;
      inhibit_r <= 1'b0;
    end else begin
      clr_pulse_r <= 1'b0;
      if (S_AXI_AWVALID_I & S_AXI_AWREADY_O) begin
        S_AXI_AWREADY_O <= 1'b0;
        aw_got_r <= 1'b1;
        awaddr_r <= S_AXI_AWADDR_I;
      end else if (~aw_got_r & ~S_AXI_BVALID_O) begin
        S_AXI_AWREADY_O <= 1'b1;
      end
      if (S_AXI_WVALID_I & S_AXI_WREADY_O) begin
        S_AXI_WREADY_O <= 1'b0;
        w_got_r <= 1'b1;
        wdata_r <= S_AXI_WDATA_I;
        wstrb0_r <= S_AXI_WSTRB_I[0];
      end else if (~w_got_r & ~S_AXI_BVALID_O) begin
        S_AXI_WREADY_O <= 1'b1;
      end
      if (do_reg_wr) begin
        S_AXI_BVALID_O <= 1'b1;
        S_AXI_BRESP_O <= aw_known ? `DCF_RESP_OKAY : `DCF_RESP_SLVERR;
        if ((awaddr_r == `DCF_REG_CTRL) & wstrb0_r) begin
          clr_pulse_r <= wdata_r[`DCF_CTRL_CLEAR];
          inhibit_r <= wdata_r[`DCF_CTRL_INHIBIT];
        end
      end else if (S_AXI_BVALID_O & S_AXI_BREADY_I) begin
        S_AXI_BVALID_O <= 1'b0;
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
      end
      if (S_AXI_ARVALID_I & S_AXI_ARREADY_O) begin
        S_AXI_ARREADY_O <= 1'b0;
        S_AXI_RVALID_O <= 1'b1;
        S_AXI_RDATA_O <= rd_mux;
        S_AXI_RRESP_O <= ar_known ? `DCF_RESP_OKAY : `DCF_RESP_SLVERR;
      end else if (S_AXI_RVALID_O & S_AXI_RREADY_I) begin
        S_AXI_RVALID_O <= 1'b0;
      end else if (~S_AXI_RVALID_O) begin
        S_AXI_ARREADY_O <= 1'b1;
      end
    end
  end

endmodule // dcf_fifo

// File: tb/dcf_fifo_monitor.sv
`timescale 1ns/1ps
module dcf_fifo_monitor #(
  parameter WIDTH = 18
) (
  // pins
  input wire CLK_I,
  input wire RST_I,
  input wire OUT_EN_N_I,
  input wire FULL_RESET_INPUT_N_I,
  input wire SOFT_CLEAR_INPUT_N_I,
  input wire [WIDTH-1:0] DATA_OUT_BUS_O,
  input wire DATA_OUT_EN_N_O,
  input wire HALF_FULL_LEVEL_N_O,
  // axi
  input wire S_AXI_AWVALID_I,
  input wire S_AXI_AWREADY_O,
  input wire S_AXI_WVALID_I,
  input wire S_AXI_WREADY_O,
  input wire S_AXI_BVALID_O,
  input wire S_AXI_BREADY_I,
  input wire [7:0] S_AXI_ARADDR_I,
  input wire S_AXI_ARVALID_I,
  input wire S_AXI_ARREADY_O,
  input wire [31:0] S_AXI_RDATA_O,
  input wire [1:0] S_AXI_RRESP_O,
  input wire S_AXI_RVALID_O,
  input wire S_AXI_RREADY_I
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  a_write_answer: assert property (S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I
    && S_AXI_WREADY_O |=> !S_AXI_AWREADY_O ##1 S_AXI_BVALID_O) else $error("write answer late");
  a_write_close: assert property (S_AXI_BVALID_O && S_AXI_BREADY_I
    |=> !S_AXI_BVALID_O ##1 S_AXI_AWREADY_O) else $error("write response not closed");
  a_read_answer: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O
    |=> S_AXI_RVALID_O && !S_AXI_ARREADY_O) else $error("read answer late");
  a_read_close: assert property (S_AXI_RVALID_O && S_AXI_RREADY_I
    |=> !S_AXI_RVALID_O ##1 S_AXI_ARREADY_O) else $error("read response not closed");
  a_unmapped_read: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O && S_AXI_ARADDR_I == 8'h0C
    |=> S_AXI_RRESP_O == 2'h2 && S_AXI_RDATA_O == 32'h0000_0000) else $error("unmapped read ok");
  a_oe_follow: assert property ($changed(OUT_EN_N_I)
    |-> ##[1:5] DATA_OUT_EN_N_O == OUT_EN_N_I) else $error("output enable not followed");
  a_master_clear: assert property (!FULL_RESET_INPUT_N_I [*8]
    |-> DATA_OUT_BUS_O == {WIDTH{1'b0}} && HALF_FULL_LEVEL_N_O) else $error("master reset");
  a_partial_clear: assert property (!SOFT_CLEAR_INPUT_N_I [*8]
    |-> DATA_OUT_BUS_O == {WIDTH{1'b0}} && HALF_FULL_LEVEL_N_O) else $error("partial reset");
endmodule // dcf_fifo_monitor
bind dcf_fifo dcf_fifo_monitor #(.WIDTH(WIDTH)) u_mon (.*);

// File: tb/dcf_peer.sv
`timescale 1ns/1ps
module dcf_peer (
  // system
  input wire clk_i,
  // producer and consumer pins
  output reg wclk_o,
  output reg wen_n_o,
  output reg [17:0] din_o,
  output reg rclk_o,
  output reg ren_n_o
);
  initial begin
    wclk_o = 1'b0;
    wen_n_o = 1'b1;
    din_o = 18'h0_0000;
    rclk_o = 1'b0;
    ren_n_o = 1'b1;
  end
  task put(input [17:0] w);
    begin
      wen_n_o <= 1'b0;
      din_o <= w;
      repeat (4) @(posedge clk_i);
      wclk_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      wclk_o <= 1'b0;
      wen_n_o <= 1'b1;
      din_o <= ~w;
      @(posedge clk_i);
    end
  endtask
  task get;
    begin
      ren_n_o <= 1'b0;
      repeat (4) @(posedge clk_i);
      rclk_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      rclk_o <= 1'b0;
      ren_n_o <= 1'b1;
      @(posedge clk_i);
    end
  endtask
  task tick(input integer n);
    repeat (n) begin
      rclk_o <= ~rclk_o;
      repeat (4) @(posedge clk_i);
    end
  endtask
endmodule // dcf_peer

// File: tb/tb_dual_clock_sync_fifo_x18.sv
`timescale 1ns/1ps
module tb_dual_clock_sync_fifo_x18;
  localparam DEP = 256;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg oe_n = 1'b0, rt_n = 1'b1, mrs_n = 1'b1, prs_n = 1'b1, ld_n = 1'b1, mode = 1'b0;
  reg [7:0] awa = 8'h00, ara = 8'h00;
  reg awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  reg [31:0] wd = 32'h0000_0000;
  wire wclk, wen_n, rclk, ren_n, doe_n, ef, ff, hf_n, ae_n, af_n, stby, awr, wr, bv, arr, rv;
  wire [17:0] din, dout;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  integer seed = 32'h0a29_8983;
  integer n_fail = 0, n_checks = 0, i;
  reg [17:0] mem [0:DEP-1];
  reg [31:0] d, v;
  reg sen_n = 1'b1;
  reg [3:0] ws = 4'hF;
  integer k;
  reg [1:0] r;
  always #20 clk = ~clk;
  dcf_peer u_peer (.clk_i(clk), .wclk_o(wclk), .wen_n_o(wen_n), .din_o(din), .rclk_o(rclk),
    .ren_n_o(ren_n));
  dcf_fifo #(.DEPTH(DEP), .ADDR_W(8)) u_dut (
    .CLK_I(clk), .RST_I(rst), .WRITE_CLK_I(wclk), .WRITE_EN_N_I(wen_n), .DATA_IN_BUS_I(din),
    .READ_CLK_I(rclk), .READ_EN_N_I(ren_n), .OUT_EN_N_I(oe_n), .RETRANSMIT_STROBE_N_I(rt_n),
    .FULL_RESET_INPUT_N_I(mrs_n), .SOFT_CLEAR_INPUT_N_I(prs_n), .OFFSET_LOAD_SELECT_N_I(ld_n),
    .SERIAL_LOAD_ENABLE_N_I(sen_n), .MODE_SELECT_SERIAL_IN_I(mode), .DATA_OUT_BUS_O(dout),
    .DATA_OUT_EN_N_O(doe_n), .EMPTY_FLAG_O(ef), .FULL_FLAG_O(ff), .HALF_FULL_LEVEL_N_O(hf_n),
    .ALMOST_EMPTY_FLAG_N_O(ae_n), .ALMOST_FULL_FLAG_N_O(af_n), .STANDBY_O(stby),
    .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd),
    .S_AXI_WSTRB_I(ws), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr), .S_AXI_BRESP_O(bresp),
    .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(br), .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv),
    .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rv),
    .S_AXI_RREADY_I(rr));
  function [4:0] flags(input integer c, input integer o);
    flags = {c + o <= DEP, c >= o, c <= DEP / 2, c != DEP, c != 0};
  endfunction
  task chk(input [31:0] g, input [31:0] e);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("Error at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  task wt(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task rd(input [7:0] a);
    begin
      ara <= a;
      arv <= 1'b1;
      rr <= 1'b1;
      do @(posedge clk); while (arr !== 1'b1);
      arv <= 1'b0;
      do @(posedge clk); while (rv !== 1'b1);
      rr <= 1'b0;
      d = rdata;
      r = rresp;
      @(posedge clk);
    end
  endtask
  task wrt(input [7:0] a, input [31:0] v);
    reg ta, tw;
    begin
      awa <= a;
      wd <= v;
      awv <= 1'b1;
      wv <= 1'b1;
      br <= 1'b1;
      ta = 1'b0;
      tw = 1'b0;
      while (!(ta && tw)) begin
        @(posedge clk);
        if (awr === 1'b1) begin
          ta = 1'b1;
          awv <= 1'b0;
        end
        if (wr === 1'b1) begin
          tw = 1'b1;
          wv <= 1'b0;
        end
      end
      do @(posedge clk); while (bv !== 1'b1);
      br <= 1'b0;
      r = bresp;
      @(posedge clk);
    end
  endtask
  task mrst(input ft, input l);
    begin
      mode <= ft;
      ld_n <= l;
      mrs_n <= 1'b0;
      wt(10);
      mrs_n <= 1'b1;
      wt(4);
      ld_n <= 1'b1;
      wt(4);
    end
  endtask
  task putn(input integer n);
    for (i = 0; i < n; i = i + 1) begin
      d = $random(seed);
      if (i < DEP) mem[i] = d[17:0];
      u_peer.put(d[17:0]);
    end
  endtask
  task test_done;
    begin
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  initial begin
    wt(40000);
    n_fail = n_fail + 1;
    test_done;
  end
  initial begin
    wt(4);
    rst <= 1'b0;
    wt(2);
    for (i = 0; i < 2; i = i + 1) begin
      mrst(1'b0, i[0]);
      wt(4);
      chk(stby, 1'b1);
      rd(8'h08);
      chk(d, i ? 32'h03FF_03FF : 32'h007F_007F);
      rd(8'h04);
      chk({d[25:24], d[20:16], d[13:0]}, {i[0], 1'b0, flags(0, i ? 1023 : 127), 14'h0000});
      chk({af_n, ae_n, hf_n, ff, ef}, flags(0, i ? 1023 : 127));
    end
    rd(8'h0C);
    chk({d, r}, {32'h0000_0000, 2'h2});
    wrt(8'h0C, 32'h0000_0001);
    chk(r, 2'h2);
    $display("test defaults done");
    mrst(1'b0, 1'b0);
    putn(DEP + 1);
    wt(4);
    chk({af_n, ae_n, hf_n, ff, ef, dout}, {flags(DEP, 127), 18'h0_0000});
    for (i = 0; i < DEP; i = i + 1) begin
      u_peer.get;
      chk(dout, mem[i]);
      chk({af_n, ae_n, hf_n, ff, ef}, flags(DEP - 1 - i, 127));
    end
    u_peer.get;
    chk(dout, mem[DEP-1]);
    $display("test fill done");
    prs_n <= 1'b0;
    wt(10);
    prs_n <= 1'b1;
    wt(4);
    chk({af_n, ae_n, hf_n, ff, ef, dout}, {flags(0, 127), 18'h0_0000});
    rd(8'h08);
    chk(d, 32'h007F_007F);
    putn(3);
    u_peer.get;
    u_peer.get;
    rt_n <= 1'b0;
    u_peer.tick(2);
    rt_n <= 1'b1;
    chk(ef, 1'b0);
    rd(8'h04);
    chk(d[13:0], 14'h0003);
    u_peer.tick(2);
    for (i = 0; i < 3; i = i + 1) begin
      u_peer.get;
      chk(dout, mem[i]);
    end
    $display("test retransmit done");
    for (k = 0; k < 2; k = k + 1) begin
      mrst(1'b0, k[0]);
      v = $random(seed);
      ld_n <= 1'b0;
      sen_n <= ~k[0];
      if (k) begin
        for (i = 25; i >= 0; i = i - 1) begin
          mode <= v[i];
          u_peer.put(18'h0_0000);
        end
      end else begin
        u_peer.put(v[17:0]);
        u_peer.put(v[30:13]);
      end
      sen_n <= 1'b1;
      u_peer.get;
      chk(dout, {5'h00, v[12:0]});
      u_peer.get;
      chk(dout, {5'h00, v[25:13]});
      ld_n <= 1'b1;
      rd(8'h08);
      chk(d, {3'h0, v[25:13], 3'h0, v[12:0]});
      wt(2);
      chk({af_n, ae_n}, {v[25:13] <= DEP, v[12:0] == 13'h0000});
    end
    $display("test program done");
    ws <= 4'hE;
    wrt(8'h00, 32'h0000_0002);
    rd(8'h00);
    chk(d, 32'h0000_0000);
    ws <= 4'hF;
    wrt(8'h00, 32'h0000_0002);
    u_peer.put(18'h0_1234);
    rd(8'h04);
    chk(d[13:0], 14'h0000);
    rd(8'h00);
    chk(d, 32'h0000_0002);
    wrt(8'h00, 32'h0000_0000);
    $display("test strobe done");
    mrst(1'b1, 1'b0);
    rd(8'h04);
    chk(d[25:24], 2'h1);
    putn(2);
    wt(4);
    chk({ef, dout}, {1'b1, 18'h0_0000});
    u_peer.tick(3);
    wt(1);
    chk({ef, ff, dout}, {2'h0, mem[0]});
    u_peer.tick(1);
    u_peer.get;
    chk({ef, dout}, {1'b0, mem[1]});
    u_peer.get;
    chk(ef, 1'b1);
    oe_n <= 1'b1;
    wt(6);
    chk(doe_n, 1'b1);
    oe_n <= 1'b0;
    wt(6);
    chk(doe_n, 1'b0);
    wrt(8'h00, 32'h0000_0001);
    chk(r, 2'h0);
    wt(4);
    chk({ef, dout}, {1'b1, 18'h0_0000});
    $display("test fall_through done");
    test_done;
  end
endmodule // tb_dual_clock_sync_fifo_x18
